// >>> core/tifp_glitch_filter.sv
// Digital glitch filter for one conditioned input line.
// Assumes the input is synchronous to clk_i and the code comes from a register.
`timescale 1ns/1ps
module tifp_glitch_filter (
  // Clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Line and configuration
  input  wire logic       din_i,
  input  wire logic [2:0] cfg_i,
  output logic            dout_o
);
  import tifp_pkg::*;

  logic [2:0] div_r;
  logic [2:0] div_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic       dout_r;
  logic       dout_nxt;
  logic       smp;
  logic       at_last;

  assign smp     = ce_i && flt_hit(cfg_i, div_r);
  assign at_last = smp && (din_i != dout_r) && (3'(cnt_r + 3'h1) >= flt_samples(cfg_i));
  assign dout_o  = dout_r;

  // The divider runs free so a code change never restarts a slow sampling period.
  always_comb begin
    div_nxt  = 3'(div_r + 3'h1);
    cnt_nxt  = cnt_r;
    dout_nxt = dout_r;
    if (cfg_i == FLT_BYPASS) begin
      dout_nxt = din_i;
      cnt_nxt  = 3'h0;
    end else if (smp) begin
      if (din_i == dout_r) begin
        cnt_nxt = 3'h0;
      end else if (at_last) begin
        dout_nxt = din_i;
        cnt_nxt  = 3'h0;
      end else begin
        cnt_nxt = 3'(cnt_r + 3'h1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r  <= 3'h0;
      cnt_r  <= 3'h0;
      dout_r <= 1'b0;
    end else if (ce_i) begin
      div_r  <= div_nxt;
      cnt_r  <= cnt_nxt;
      dout_r <= dout_nxt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  filt_change_a: assert property ($changed(dout_r) |-> $past(cfg_i == FLT_BYPASS) || $past(at_last))
    else $error("Filter output changed without enough samples.");
  fast_pair_a: assert property ((ce_i && cfg_i == 3'h1 && din_i != dout_r) ##1
      (ce_i && cfg_i == 3'h1 && $stable(din_i) && din_i != dout_r) |=> dout_r == $past(din_i))
    else $error("Two-sample filter did not follow a steady input.");
  samp_pace_a: assert property (smp && cfg_i[2] |=> (!smp || !cfg_i[2])[*3])
    else $error("Slow sampling ticked too often.");
  cover property (cfg_i != FLT_BYPASS && $changed(dout_r));
endmodule

// >>> core/tifp_pkg.sv
// Constants, register map and filter decoding for the timer input filter and prescaler.
// Assumes a classic Wishbone slave with byte addresses and a 50 MHz peripheral clock.
// Behaviour
// - Channel invert bits 3,7,11,15 pass the pin inverted when set, unchanged when clear.
// - Channel filter fields sit at 2:0, 6:4, 10:8 and 14:12, same coding.
// - Code 000 bypasses; 001, 010, 011 sample every clock with N of 2, 4, 6.
// - Trigger filter field at bits 6:4; 000 bypasses; 001-011 every clock, N 2,4,6.
// - Trigger codes 100,101 sample at clock/4, 110,111 at clock/8, N 4 or 6.
// - In peripheral-clock modes the count tick is the clock divided by prescale plus one.
// - In trigger-count mode the source is divided by exactly prescale; software keeps it nonzero.
// - Channel control register resets to zero: non-inverted and unfiltered.
// - Prescale and trigger filter registers reset to zero: divide by one, no filter.
// - Mode 01 counts trigger-source edges; modes 00, 10, 11 count the peripheral clock.
package tifp_pkg;

  // Byte offsets of the registers.
  localparam logic [7:0] OFF_TRIG_FILTER = 8'h0c;
  localparam logic [7:0] OFF_CHAN_CTRL   = 8'h30;
  localparam logic [7:0] OFF_PRESCALE    = 8'h34;
  localparam logic [7:0] OFF_COUNT_MODE  = 8'h38;
  localparam logic [7:0] OFF_STATUS      = 8'h3c;

  // Field positions.
  localparam int CHAN_STRIDE    = 4;
  localparam int CHAN_CFG_LSB   = 0;
  localparam int CHAN_INV_BIT   = 3;
  localparam int TRIG_CFG_LSB   = 4;
  localparam int PSC_LSB        = 0;
  localparam int MODE_LSB       = 0;

  // Reset values.
  localparam logic [15:0] CHAN_CTRL_RST = 16'h0000;
  localparam logic [15:0] PRESCALE_RST  = 16'h0000;
  localparam logic [2:0]  TRIG_CFG_RST  = 3'h0;
  localparam logic [1:0]  MODE_RST      = 2'h0;

  // Basic mode whose counting clock is the trigger-source signal.
  localparam logic [1:0] MODE_TRIG_COUNT = 2'h1;

  // Filter coding.
  localparam logic [2:0] FLT_BYPASS   = 3'h0;
  localparam logic [2:0] SAMPLES_LOW  = 3'h2;
  localparam logic [2:0] SAMPLES_MID  = 3'h4;
  localparam logic [2:0] SAMPLES_HIGH = 3'h6;
  localparam logic [1:0] DIV4_LAST    = 2'h3;
  localparam logic [2:0] DIV8_LAST    = 3'h7;

  // Sample count N for a filter code.
  function automatic logic [2:0] flt_samples(input logic [2:0] cfg);
    case (cfg)
      3'h1:    flt_samples = SAMPLES_LOW;
      3'h2:    flt_samples = SAMPLES_MID;
      3'h4:    flt_samples = SAMPLES_MID;
      3'h6:    flt_samples = SAMPLES_MID;
      default: flt_samples = SAMPLES_HIGH;
    endcase
  endfunction

  // True on cycles where the code's sampling clock ticks.
  function automatic logic flt_hit(input logic [2:0] cfg, input logic [2:0] div);
    if (!cfg[2]) begin
      flt_hit = 1'b1;
    end else if (!cfg[1]) begin
      flt_hit = (div[1:0] == DIV4_LAST);
    end else begin
      flt_hit = (div == DIV8_LAST);
    end
  endfunction

  // Byte-lane merge of a Wishbone write into a register word.
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      wb_merge[b*8 +: 8] = sel[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
    end
  endfunction

endpackage

// >>> core/tifp_top.sv
// Channel polarity, channel and trigger glitch filters, and the count prescaler.
// Assumes a classic Wishbone master and pin inputs synchronous to clk_i.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
module tifp_top (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Input pins and trigger source
  input  wire logic [3:0]  chan_pin_i,
  input  wire logic        external_trigger_input_i,
  input  wire logic        trigger_source_signal_i,
  // Conditioned outputs
  output logic [3:0]       chan_cond_o,
  output logic             trigger_cond_o,
  output logic             divided_count_clock_o
);
  import tifp_pkg::*;

  // Register state.
  logic [15:0] chan_ctrl_r;
  logic [15:0] chan_ctrl_nxt;
  logic [15:0] psc_r;
  logic [15:0] psc_nxt;
  logic [2:0]  trig_cfg_r;
  logic [2:0]  trig_cfg_nxt;
  logic [1:0]  mode_r;
  logic [1:0]  mode_nxt;
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;

  // Prescaler state.
  logic [15:0] pcnt_r;
  logic [15:0] pcnt_nxt;
  logic        tick_r;
  logic        tick_nxt;
  logic        src_prev_r;
  logic        src_prev_nxt;

  logic        acc;
  logic [3:0]  chan_in;
  logic [3:0]  chan_filt;
  logic        trig_filt;
  logic        pclk_mode;
  logic        src_rise;
  logic        cnt_event;
  logic [15:0] limit;

  assign acc = wb_cyc_i && wb_stb_i && !ack_r;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  // Bus slave: the answer is registered, so ack rises one cycle after the request.
  always_comb begin
    chan_ctrl_nxt = chan_ctrl_r;
    psc_nxt       = psc_r;
    trig_cfg_nxt  = trig_cfg_r;
    mode_nxt      = mode_r;
    ack_nxt       = acc;
    dat_nxt       = dat_r;
    if (acc && wb_we_i) begin
      if (hit(wb_adr_i, OFF_CHAN_CTRL)) begin
        chan_ctrl_nxt = 16'(wb_merge({16'h0000, chan_ctrl_r}, wb_dat_i, wb_sel_i));
      end
      if (hit(wb_adr_i, OFF_PRESCALE)) begin
        psc_nxt = 16'(wb_merge({16'h0000, psc_r}, wb_dat_i, wb_sel_i));
      end
      if (hit(wb_adr_i, OFF_TRIG_FILTER) && wb_sel_i[0]) begin
        trig_cfg_nxt = wb_dat_i[TRIG_CFG_LSB +: 3];
      end
      if (hit(wb_adr_i, OFF_COUNT_MODE) && wb_sel_i[0]) begin
        mode_nxt = wb_dat_i[MODE_LSB +: 2];
      end
    end
    if (acc) begin
      // Reserved bits and unmapped words read as zero.
      dat_nxt = 32'h0000_0000;
      if (hit(wb_adr_i, OFF_CHAN_CTRL)) begin
        dat_nxt[15:0] = chan_ctrl_r;
      end
      if (hit(wb_adr_i, OFF_PRESCALE)) begin
        dat_nxt[PSC_LSB +: 16] = psc_r;
      end
      if (hit(wb_adr_i, OFF_TRIG_FILTER)) begin
        dat_nxt[TRIG_CFG_LSB +: 3] = trig_cfg_r;
      end
      if (hit(wb_adr_i, OFF_COUNT_MODE)) begin
        dat_nxt[MODE_LSB +: 2] = mode_r;
      end
      if (hit(wb_adr_i, OFF_STATUS)) begin
        dat_nxt[4:0] = {trigger_cond_o, chan_cond_o};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_ctrl_r <= CHAN_CTRL_RST;
      psc_r       <= PRESCALE_RST;
      trig_cfg_r  <= TRIG_CFG_RST;
      mode_r      <= MODE_RST;
      ack_r       <= 1'b0;
      dat_r       <= 32'h0000_0000;
    end else if (ce_i) begin
      chan_ctrl_r <= chan_ctrl_nxt;
      psc_r       <= psc_nxt;
      trig_cfg_r  <= trig_cfg_nxt;
      mode_r      <= mode_nxt;
      ack_r       <= ack_nxt;
      dat_r       <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Polarity select ahead of each channel filter.
  for (genvar c = 0; c < 4; c++) begin : g_chan
    assign chan_in[c] = chan_pin_i[c] ^ chan_ctrl_r[c*CHAN_STRIDE + CHAN_INV_BIT];
    tifp_glitch_filter u_filt (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .din_i  (chan_in[c]),
      .cfg_i  (chan_ctrl_r[c*CHAN_STRIDE + CHAN_CFG_LSB +: 3]),
      .dout_o (chan_filt[c])
    );
  end

  tifp_glitch_filter u_trig_filt (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .din_i  (external_trigger_input_i),
    .cfg_i  (trig_cfg_r),
    .dout_o (trig_filt)
  );

  assign chan_cond_o    = chan_filt;
  assign trigger_cond_o = trig_filt;

  // Prescaler. A zero prescale in trigger mode divides by one rather than stalling.
  assign pclk_mode = (mode_r != MODE_TRIG_COUNT);
  assign src_rise  = trigger_source_signal_i && !src_prev_r;
  assign cnt_event = pclk_mode || src_rise;
  assign limit     = pclk_mode ? psc_r :
                     ((psc_r == 16'h0000) ? 16'h0000 : 16'(psc_r - 16'h0001));

  always_comb begin
    pcnt_nxt     = pcnt_r;
    tick_nxt     = 1'b0;
    src_prev_nxt = trigger_source_signal_i;
    if (cnt_event) begin
      if (pcnt_r >= limit) begin
        pcnt_nxt = 16'h0000;
        tick_nxt = 1'b1;
      end else begin
        pcnt_nxt = 16'(pcnt_r + 16'h0001);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcnt_r     <= 16'h0000;
      tick_r     <= 1'b0;
      src_prev_r <= 1'b0;
    end else if (ce_i) begin
      pcnt_r     <= pcnt_nxt;
      tick_r     <= tick_nxt;
      src_prev_r <= src_prev_nxt;
    end
  end

  assign divided_count_clock_o = tick_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  pol_pass_a: assert property (ce_i && chan_ctrl_r[2:0] == FLT_BYPASS
      |=> chan_cond_o[0] == $past(chan_pin_i[0] ^ chan_ctrl_r[CHAN_INV_BIT]))
    else $error("Channel one polarity path wrong.");
  trig_pass_a: assert property (ce_i && trig_cfg_r == FLT_BYPASS
      |=> trigger_cond_o == $past(external_trigger_input_i))
    else $error("Unfiltered trigger did not pass.");
  div_one_a: assert property (ce_i && pclk_mode && psc_r == 16'h0000 |=> divided_count_clock_o)
    else $error("Divide by one missed a tick.");
  div_three_a: assert property ((ce_i && pclk_mode && psc_r == 16'h0002)[*3]
      |=> $countones({divided_count_clock_o, $past(divided_count_clock_o),
                      $past(divided_count_clock_o, 2)}) == 1)
    else $error("Prescale two did not divide by three.");
  trig_edge_a: assert property (ce_i && !pclk_mode && psc_r == 16'h0001 && src_rise
      |=> divided_count_clock_o)
    else $error("Trigger mode prescale one missed an edge.");
  trig_only_a: assert property (ce_i && !pclk_mode && !src_rise |=> !divided_count_clock_o)
    else $error("Trigger mode ticked without a source edge.");
  reset_clr_a: assert property (@(posedge clk_i) disable iff (1'b0) rst_i
      |=> chan_ctrl_r == 16'h0000 && psc_r == 16'h0000 && trig_cfg_r == 3'h0)
    else $error("Registers not cleared by reset.");
  psc_write_a: assert property (acc && ce_i && wb_we_i && wb_sel_i == 4'hf
      && hit(wb_adr_i, OFF_PRESCALE) |=> psc_r == $past(wb_dat_i[15:0]) && wb_ack_o)
    else $error("Prescale write not taken.");
  ack_once_a: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held too long.");

  // Register bus: a taken request is answered at the next edge with the stored word.
  ack_next_a: assert property (
      acc && ce_i
      |=> wb_ack_o)
    else $error("Taken request was not acknowledged.");

  ack_idle_a: assert property (
      ce_i && !wb_cyc_i
      |=> !wb_ack_o)
    else $error("Acknowledge without a cycle.");

  chan_write_a: assert property (
      acc && ce_i && wb_we_i && wb_sel_i == 4'hf && hit(wb_adr_i, OFF_CHAN_CTRL)
      |=> chan_ctrl_r == $past(wb_dat_i[15:0]))
    else $error("Channel control write not taken.");

  trig_write_a: assert property (
      acc && ce_i && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, OFF_TRIG_FILTER)
      |=> trig_cfg_r == $past(wb_dat_i[TRIG_CFG_LSB +: 3]))
    else $error("Trigger filter write not taken.");

  mode_write_a: assert property (
      acc && ce_i && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, OFF_COUNT_MODE)
      |=> mode_r == $past(wb_dat_i[MODE_LSB +: 2]))
    else $error("Count mode write not taken.");

  chan_read_a: assert property (
      acc && ce_i && hit(wb_adr_i, OFF_CHAN_CTRL)
      |=> wb_dat_o == {16'h0000, $past(chan_ctrl_r)})
    else $error("Channel control read wrong.");

  psc_read_a: assert property (
      acc && ce_i && hit(wb_adr_i, OFF_PRESCALE)
      |=> wb_dat_o == {16'h0000, $past(psc_r)})
    else $error("Prescale read wrong.");

  trig_read_a: assert property (
      acc && ce_i && hit(wb_adr_i, OFF_TRIG_FILTER)
      |=> wb_dat_o == {25'h000_0000, $past(trig_cfg_r), 4'h0})
    else $error("Trigger filter read wrong.");

  hole_read_a: assert property (
      acc && ce_i && !hit(wb_adr_i, OFF_CHAN_CTRL) && !hit(wb_adr_i, OFF_PRESCALE)
      && !hit(wb_adr_i, OFF_TRIG_FILTER) && !hit(wb_adr_i, OFF_COUNT_MODE)
      && !hit(wb_adr_i, OFF_STATUS)
      |=> wb_dat_o == 32'h0000_0000)
    else $error("Unmapped word did not read zero.");

  // Prescaler: every tick restarts the count, so ticks never abut unless dividing by one.
  div_gap_a: assert property (
      ce_i && psc_r != 16'h0000 && divided_count_clock_o
      |=> !divided_count_clock_o)
    else $error("Two ticks in a row with a nonzero prescale.");

  trig_zero_a: assert property (
      ce_i && !pclk_mode && psc_r == 16'h0000 && src_rise
      |=> divided_count_clock_o)
    else $error("Trigger mode prescale zero missed an edge.");

  pcnt_hold_a: assert property (
      ce_i && !cnt_event
      |=> pcnt_r == $past(pcnt_r))
    else $error("Prescale count moved without an event.");

  // A low enable must hold every register, the filters included.
  freeze_a: assert property (
      !ce_i
      |=> $stable(chan_ctrl_r) && $stable(psc_r) && $stable(pcnt_r) && $stable(wb_ack_o)
          && $stable(chan_cond_o) && $stable(trigger_cond_o))
    else $error("State moved while the enable was low.");

  reset_out_a: assert property (@(posedge clk_i) disable iff (1'b0) rst_i
      |=> !wb_ack_o && wb_dat_o == 32'h0000_0000 && !divided_count_clock_o
          && chan_cond_o == 4'h0 && !trigger_cond_o && mode_r == MODE_RST)
    else $error("Outputs not cleared by reset.");

  for (genvar c = 1; c < 4; c++) begin : g_pol_chk
    pol_rest_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && chan_ctrl_r[c*CHAN_STRIDE + CHAN_CFG_LSB +: 3] == FLT_BYPASS
        |=> chan_cond_o[c] == $past(chan_pin_i[c] ^ chan_ctrl_r[c*CHAN_STRIDE + CHAN_INV_BIT]))
      else $error("Channel polarity path wrong.");
  end

  cover property (ce_i && !pclk_mode && psc_r == 16'h0003 && divided_count_clock_o);
  cover property (chan_ctrl_r[14:12] == 3'h7 && $changed(chan_cond_o[3]));
  cover property (wb_ack_o && $past(hit(wb_adr_i, OFF_STATUS)));
  cover property ($rose(ce_i));
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the input filter and prescaler block.
// Assumes one 50 MHz clock, the pin model beside it and a classic Wishbone master here.
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ce = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, rdat;
  logic [31:0] dat_o;
  logic        ack;
  logic [3:0]  pins, cond;
  logic        tpin, src, tcond, tick;
  int miscompares = 0, comparisons = 0, pulses = 0;
  int n_tab[8] = '{1, 2, 4, 6, 4, 6, 4, 6};
  int d_tab[8] = '{1, 1, 1, 1, 4, 4, 8, 8};

  always #10 clk_i = ~clk_i;
  // Counting on the falling edge keeps the tally settled whenever a task reads it.
  always @(negedge clk_i) if (tick === 1'b1) pulses++;

  tifp_top u_tifp_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .chan_pin_i(pins), .external_trigger_input_i(tpin),
    .trigger_source_signal_i(src), .chan_cond_o(cond), .trigger_cond_o(tcond),
    .divided_count_clock_o(tick));
  tifp_pin_model u_tifp_pin_model (.clk_i(clk_i), .chan_pin_o(pins), .trig_pin_o(tpin),
    .src_o(src));

  task automatic finish_test;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Single classic cycle; the wait is bounded only by the watchdog.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic reset_values;
    int base;
    base = pulses;
    repeat (6) @(posedge clk_i);
    check(32'(pulses - base), 32'h0000_0005);
    foreach (n_tab[i]) if (i < 4) begin
      wb(1'b0, i[1:0] == 0 ? 8'h0c : i[1:0] == 1 ? 8'h30 : i[1:0] == 2 ? 8'h34 : 8'h20, 0);
      check(rdat, 32'h0000_0000);
    end
  endtask

  // Steps the pin and checks the output holds for (N-1) periods and follows by N.
  task automatic flt_step(input bit trig, input int ch, input logic [2:0] code);
    logic lvl;
    int n, d;
    n = n_tab[code];
    d = d_tab[code];
    if (trig) wb(1'b1, 8'h0c, {25'h0, code, 4'h0});
    else wb(1'b1, 8'h30, 32'(code) << (4 * ch));
    wb(1'b0, trig ? 8'h0c : 8'h30, 0);
    check(rdat, trig ? {25'h0, code, 4'h0} : 32'(code) << (4 * ch));
    repeat (60) @(posedge clk_i);
    lvl = trig ? tpin : pins[ch];
    check(trig ? tcond : cond[ch], lvl);
    if (trig) u_tifp_pin_model.set_trig(~lvl);
    else u_tifp_pin_model.set_chan(pins ^ (4'h1 << ch));
    repeat ((n - 1) * d) @(posedge clk_i);
    #1 if (n * d > 1) check(trig ? tcond : cond[ch], lvl);
    repeat (d) @(posedge clk_i);
    #1 check(trig ? tcond : cond[ch], !lvl);
  endtask

  task automatic polarity;
    wb(1'b1, 8'h30, 32'h0000_8888);
    u_tifp_pin_model.set_chan(4'h0);
    repeat (3) @(posedge clk_i);
    check(cond, 4'hf);
    u_tifp_pin_model.set_chan(4'h5);
    repeat (3) @(posedge clk_i);
    check(cond, 4'ha);
    wb(1'b0, 8'h30, 0);
    check(rdat, 32'h0000_8888);
    wb(1'b0, 8'h3c, 0);
    check(rdat, 32'h0000_000a);
  endtask

  // Any window of 6(P+1) cycles holds exactly six ticks whatever the phase.
  task automatic psc_window(input logic [1:0] mode, input logic [15:0] p);
    int base;
    wb(1'b1, 8'h38, {30'h0, mode});
    wb(1'b0, 8'h38, 0);
    check(rdat, {30'h0, mode});
    wb(1'b1, 8'h34, {16'h0, p});
    repeat (2 * (p + 1)) @(posedge clk_i);
    base = pulses;
    repeat (6 * (p + 1)) @(posedge clk_i);
    check(32'(pulses - base), 32'h0000_0006);
  endtask

  task automatic trig_count(input int gap, input logic [15:0] p);
    int base, k;
    wb(1'b1, 8'h34, {16'h0, p});
    wb(1'b1, 8'h38, 32'h0000_0001);
    base = pulses;
    repeat (20) @(posedge clk_i);
    check(32'(pulses - base), 32'h0000_0000);
    for (k = 0; k < 8 && pulses == base; k++) u_tifp_pin_model.src_edge(gap);
    base = pulses;
    for (k = 0; k < 8 && pulses == base; k++) u_tifp_pin_model.src_edge(gap);
    check(32'(k), 32'(p));
  endtask

  // Freezes the block just after a tick, so the frozen tick output is low.
  task automatic ce_hold;
    int base;
    logic [3:0] was;
    wb(1'b1, 8'h38, 32'h0000_0000);
    wb(1'b1, 8'h34, 32'h0000_0004);
    do @(posedge clk_i); while (tick !== 1'b1);
    ce <= 1'b0;
    base = pulses;
    was = cond;
    u_tifp_pin_model.set_chan(pins ^ 4'h1);
    repeat (20) @(posedge clk_i);
    check(32'(pulses - base), 32'h0000_0000);
    check(cond, was);
    ce <= 1'b1;
    base = pulses;
    repeat (25) @(posedge clk_i);
    check(32'(pulses - base), 32'h0000_0005);
    check(cond, was ^ 4'h1);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_values();
    polarity();
    for (int c = 0; c < 8; c++) begin
      flt_step(1'b1, 0, c[2:0]);
      flt_step(1'b0, c % 4, c[2:0]);
    end
    psc_window(2'h0, 16'h0000);
    psc_window(2'h2, 16'h0002);
    psc_window(2'h3, 16'h0005);
    trig_count(2, 16'h0003);
    trig_count(5, 16'h0001);
    ce_hold();
    finish_test();
  end

  // Far above the fewer than two thousand cycles the scenarios need.
  initial begin
    repeat (30000) @(posedge clk_i);
    miscompares++;
    finish_test();
  end
endmodule

// >>> test/tifp_pin_model.sv
// Model of the channel pins, trigger pin and trigger-source line outside the block.
// Assumes the bench calls its tasks and that all levels change just after a rising edge.
`timescale 1ns/1ps
module tifp_pin_model (
  // Clock
  input  wire logic clk_i,
  // Pins towards the block
  output logic [3:0] chan_pin_o,
  output logic       trig_pin_o,
  output logic       src_o
);
  initial begin
    chan_pin_o = 4'h0;
    trig_pin_o = 1'b0;
    src_o      = 1'b0;
  end

  task automatic set_chan(input logic [3:0] v);
    @(posedge clk_i);
    chan_pin_o <= v;
  endtask

  task automatic set_trig(input logic v);
    @(posedge clk_i);
    trig_pin_o <= v;
  endtask

  // A large gap models a slow source; each call makes exactly one rising edge.
  task automatic src_edge(input int gap);
    @(posedge clk_i);
    src_o <= 1'b1;
    repeat (gap) @(posedge clk_i);
    src_o <= 1'b0;
    repeat (gap) @(posedge clk_i);
  endtask
endmodule
